// File: core/cond_if.sv
interface cond_if;
    logic kick_fall;
    logic range_level;
    logic range_chg;
    logic strap_a;
    logic strap_b;
    logic strap_chg;
    logic mr_level_n;
    logic aux_ok;

    modport src (
        output kick_fall, range_level, range_chg, strap_a, strap_b,
               strap_chg, mr_level_n, aux_ok
    );
    modport dst (
        input  kick_fall, range_level, range_chg, strap_a, strap_b,
               strap_chg, mr_level_n, aux_ok
    );
endinterface

// File: core/low_filter.sv
module low_filter #(
    parameter int MIN_CYC = 125
) (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic level_n,
    output logic      active
);
    localparam int W = $clog2(MIN_CYC + 1);

    if (MIN_CYC < 1) begin : g_chk
        $error("low_filter: MIN_CYC must be at least 1");
    end

    logic [W-1:0] low_cnt;
    wire          reached = (low_cnt >= W'(MIN_CYC - 1));

    // ****************************************************************
    // qualify a low level held long enough
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            low_cnt <= '0;
            active  <= 1'b0;
        end else if (level_n) begin
            low_cnt <= '0; // RQ1
            active  <= 1'b0;
        end else begin
            low_cnt <= reached ? low_cnt : low_cnt + W'(1);
            active  <= reached; // RQ1
        end
    end
endmodule

// File: core/pin_conditioner.sv
`include "rsw_consts.svh"

module pin_conditioner (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic manual_reset_n,
    input  wire logic watchdog_kick,
    input  wire logic watchdog_range_select,
    input  wire logic window_ratio_strap_a,
    input  wire logic window_ratio_strap_b,
    input  wire logic aux_monitor_ok,
    cond_if.src       c
);
    localparam int          N    = 6;
    localparam logic [N-1:0] IDLE = `PIN_IDLE;

    logic [N-1:0] pins;
    logic [N-1:0] cur;
    logic [N-1:0] prev;

    assign pins = {aux_monitor_ok, window_ratio_strap_b, window_ratio_strap_a,
                   watchdog_range_select, watchdog_kick, manual_reset_n};

    // ****************************************************************
    // sample and previous value per pin
    // ****************************************************************
    for (genvar i = 0; i < N; i++) begin : g_pin
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                cur[i]  <= IDLE[i]; // RQ3
                prev[i] <= IDLE[i];
            end else begin
                cur[i]  <= pins[i];
                prev[i] <= cur[i];
            end
        end
    end

    // ****************************************************************
    // edges and changes
    // ****************************************************************
    assign c.mr_level_n  = cur[0];
    assign c.kick_fall   = prev[1] & ~cur[1]; // RQ23
    assign c.range_level = cur[2];
    assign c.range_chg   = prev[2] ^ cur[2];
    assign c.strap_a     = cur[3];
    assign c.strap_b     = cur[4];
    assign c.strap_chg   = (prev[3] ^ cur[3]) | (prev[4] ^ cur[4]);
    assign c.aux_ok      = cur[5];
endmodule

// File: core/reset_supervisor_watchdog.sv
// Function
// RQ1: reset only after manual input held low 1 us; 100 ns glitches ignored.
// RQ2: after manual input returns high, reset held one reset hold time.
// RQ3: unconnected manual reset input reads inactive high.
// RQ4: standard watchdog: no kick within timeout gives reset hold pulse.
// RQ5: standard counter clears on reset, falling kick, range select change.
// RQ6: standard counter held cleared in reset, counts right after release.
// RQ7: extended mode timeout is normal timeout times 128.
// RQ8: zero watchdog period setting disables the standard watchdog.
// RQ9: windowed: kick edges closer than fast or beyond slow limit reset.
// RQ10: fast limit is slow limit divided by strap ratio 8, 16 or 64.
// RQ11: strap a high with strap b low disables windowed watchdog.
// RQ12: window counter starts at reset release, restarts on valid kick.
// RQ13: windowed watchdog ignores kicks while reset asserted.
// RQ14: window counter clears on reset, falling kick, strap change.
// RQ15: processor kicks between largest fast and smallest slow limit.
// RQ16: reset hold time scales 4.94e6 seconds per farad of setting.
// RQ17: normal timeout scales 4.94e6 seconds per farad of setting.
// RQ18: slow limit scales 0.65e9 seconds per farad of setting.
// RQ19: reset period setting independent of watchdog period setting.
// RQ20: reset held while aux monitor low, then one hold time more.
// RQ21: reset while any condition active, release one hold time after.
// RQ22: range select low gives normal mode, high gives extended mode.
// RQ23: all periods are clock counts; inputs sampled and edge detected.
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
`include "rsw_consts.svh"

module reset_supervisor_watchdog #(
    parameter int          SET_W           = 20,
    parameter int          CNT_W           = 40,
    parameter int unsigned RST_SET_DEFAULT = 100,
    parameter int unsigned WDG_SET_DEFAULT = 1500
) (
    input  wire logic           mclk,
    input  wire logic           reset_n,
    // ahb-lite slave
    input  wire logic           hsel,
    input  wire logic           hready,
    input  wire logic [1:0]     htrans,
    input  wire logic [31:0]    haddr,
    input  wire logic           hwrite,
    input  wire logic [2:0]     hsize,
    input  wire rsw_pkg::word_t hwdata,
    output rsw_pkg::word_t      hrdata,
    output logic                hreadyout,
    output logic                hresp,
    // pins
    input  wire logic           manual_reset_n,
    input  wire logic           watchdog_kick,
    input  wire logic           watchdog_range_select,
    input  wire logic           window_ratio_strap_a,
    input  wire logic           window_ratio_strap_b,
    input  wire logic           aux_monitor_ok,
    output logic                proc_reset_n
);
    import rsw_pkg::*;

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    if (CNT_W < SET_W + 18 || CNT_W < 32 || CNT_W > 64) begin : g_chk_cnt
        $error("reset_supervisor_watchdog: CNT_W out of range for SET_W");
    end
    if (SET_W < 1 || SET_W > 32) begin : g_chk_set
        $error("reset_supervisor_watchdog: SET_W must be 1 to 32");
    end

    localparam logic [CNT_W-1:0] ONE = 1;

    // ****************************************************************
    // declarations
    // ****************************************************************
    sup_state_t       state;
    sup_state_t       next_state;
    logic             in_reset;
    logic             mr_active;
    logic             windowed_mode;
    logic             aux_monitor_en;
    logic [SET_W-1:0] reset_period_setting;
    logic [SET_W-1:0] watchdog_period_setting;
    logic [2:0]       fault_seen;
    logic [CNT_W-1:0] wd_cnt;
    logic [CNT_W-1:0] hold_cnt;
    logic             wr_pend;
    logic [7:0]       wr_addr;

    cond_if cif ();

    // ****************************************************************
    // pin sampling and manual reset qualification
    // ****************************************************************
    pin_conditioner u_pins (
        .mclk                  (mclk),
        .reset_n               (reset_n),
        .manual_reset_n        (manual_reset_n),
        .watchdog_kick         (watchdog_kick),
        .watchdog_range_select (watchdog_range_select),
        .window_ratio_strap_a  (window_ratio_strap_a),
        .window_ratio_strap_b  (window_ratio_strap_b),
        .aux_monitor_ok        (aux_monitor_ok),
        .c                     (cif.src)
    );

    low_filter #(
        .MIN_CYC (`MR_MIN_CYC)
    ) u_mr_filter (
        .mclk    (mclk),
        .reset_n (reset_n),
        .level_n (cif.mr_level_n),
        .active  (mr_active)
    );

    // ****************************************************************
    // period lengths in clock cycles
    // ****************************************************************
    wire [CNT_W-1:0] rst_base;
    wire [CNT_W-1:0] std_base;
    wire [CNT_W-1:0] hold_len;
    wire [CNT_W-1:0] std_len;
    wire [CNT_W-1:0] slow_len;
    wire [CNT_W-1:0] fast_len;
    wire [2:0]       ratio_shift;

    assign rst_base = CNT_W'((CNT_W'(reset_period_setting)
                      * CNT_W'(`RST_CYC_PF_X2)) >> 1); // RQ16 RQ19
    assign std_base = CNT_W'((CNT_W'(watchdog_period_setting)
                      * CNT_W'(`RST_CYC_PF_X2)) >> 1); // RQ17
    assign hold_len = (rst_base == '0) ? ONE : rst_base;
    assign std_len  = cif.range_level ? (std_base << `EXT_SHIFT) // RQ7 RQ22
                                      : std_base;
    assign slow_len = CNT_W'((CNT_W'(watchdog_period_setting)
                      * CNT_W'(`WIN_CYC_PF_X2)) >> 1); // RQ18

    assign ratio_shift = !cif.strap_b ? `RATIO_LL_SHIFT // RQ10
                       : cif.strap_a  ? `RATIO_HH_SHIFT
                       :                `RATIO_LH_SHIFT;
    assign fast_len    = slow_len >> ratio_shift; // RQ10

    // ****************************************************************
    // watchdog enables and counter clears
    // ****************************************************************
    wire setting_zero = (watchdog_period_setting == '0);
    wire strap_off    = cif.strap_a & ~cif.strap_b;
    wire std_enabled  = ~windowed_mode & ~setting_zero; // RQ8
    wire win_enabled  = windowed_mode & ~setting_zero & ~strap_off; // RQ11
    wire wd_enabled   = std_enabled | win_enabled;
    wire live_kick    = cif.kick_fall & ~in_reset; // RQ13
    wire cfg_chg      = windowed_mode ? cif.strap_chg : cif.range_chg;

    wire wd_clear = in_reset       // RQ5 RQ6 RQ14
                  | cif.kick_fall  // RQ5 RQ12 RQ14
                  | cfg_chg        // RQ5 RQ14
                  | ~wd_enabled;

    // ****************************************************************
    // fault detection
    // ****************************************************************
    wire std_fault  = std_enabled & ~wd_clear
                    & (wd_cnt >= std_len - ONE); // RQ4
    wire fast_fault = win_enabled & live_kick & ~cif.strap_chg
                    & (wd_cnt < fast_len); // RQ9
    wire slow_fault = win_enabled & ~wd_clear
                    & (wd_cnt >= slow_len - ONE); // RQ9
    wire wd_fault   = std_fault | fast_fault | slow_fault;

    wire aux_low    = aux_monitor_en & ~cif.aux_ok; // RQ20
    wire reset_cond = mr_active | aux_low | wd_fault; // RQ21

    // ****************************************************************
    // watchdog counter
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wd_cnt <= '0;
        end else if (wd_clear) begin
            wd_cnt <= '0; // RQ6 RQ12
        end else if (wd_cnt != '1) begin
            wd_cnt <= wd_cnt + ONE; // RQ23
        end
    end

    // ****************************************************************
    // reset sequencer
    // ****************************************************************
    assign in_reset = (state != ST_RUN);
    wire   hold_done = (hold_cnt >= hold_len - ONE);

    always_comb begin
        next_state = state;
        unique case (state)
            ST_RUN: begin
                if (reset_cond) begin
                    next_state = ST_HOLD; // RQ4 RQ9 RQ21
                end
            end
            ST_HOLD: begin
                if (!reset_cond) begin
                    next_state = ST_STRETCH; // RQ2 RQ20
                end
            end
            ST_STRETCH: begin
                if (reset_cond) begin
                    next_state = ST_HOLD; // RQ21
                end else if (hold_done) begin
                    next_state = ST_RUN; // RQ21
                end
            end
            default: begin
                next_state = ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state        <= ST_STRETCH;
            proc_reset_n <= 1'b0;
        end else begin
            state        <= next_state;
            proc_reset_n <= (next_state == ST_RUN);
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            hold_cnt <= '0;
        end else if (state != ST_STRETCH || reset_cond) begin
            hold_cnt <= '0;
        end else begin
            hold_cnt <= hold_cnt + ONE; // RQ2 RQ21
        end
    end

    // ****************************************************************
    // ahb-lite access decode
    // ****************************************************************
    wire addr_take = hsel & hready & htrans[1];
    wire wr_ctrl   = wr_pend & (wr_addr == `OFS_CTRL);
    wire wr_rset   = wr_pend & (wr_addr == `OFS_RST_SET);
    wire wr_wset   = wr_pend & (wr_addr == `OFS_WDOG_SET);
    wire wr_stat   = wr_pend & (wr_addr == `OFS_STATUS);

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_take & hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    // ****************************************************************
    // control and setting registers
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            {aux_monitor_en, windowed_mode} <= `CTRL_RST;
        end else if (wr_ctrl) begin
            windowed_mode  <= hwdata[`CTRL_WINDOWED];
            aux_monitor_en <= hwdata[`CTRL_AUX_EN];
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            reset_period_setting <= SET_W'(RST_SET_DEFAULT);
        end else if (wr_rset) begin
            reset_period_setting <= hwdata[SET_W-1:0]; // RQ19
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            watchdog_period_setting <= SET_W'(WDG_SET_DEFAULT);
        end else if (wr_wset) begin
            watchdog_period_setting <= hwdata[SET_W-1:0]; // RQ19
        end
    end

    // ****************************************************************
    // sticky fault flags, set wins over clear
    // ****************************************************************
    wire [2:0] fault_ev  = {std_fault, slow_fault, fast_fault};
    wire [2:0] fault_clr = wr_stat ? hwdata[`STAT_STICKY +: 3] : 3'h0;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            fault_seen <= 3'h0;
        end else begin
            fault_seen <= fault_ev | (fault_seen & ~fault_clr);
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    wire [7:0] rd_addr = haddr[7:0];
    word_t     stat_word;
    word_t     rd_mux;

    assign stat_word = {25'h0000000,
                        cif.range_level,
                        strap_off,
                        fault_seen,
                        mr_active,
                        in_reset};

    assign rd_mux = (rd_addr == `OFS_CTRL)     ? {30'h00000000, aux_monitor_en,
                                                  windowed_mode}
                  : (rd_addr == `OFS_RST_SET)  ? 32'(reset_period_setting)
                  : (rd_addr == `OFS_WDOG_SET) ? 32'(watchdog_period_setting)
                  : (rd_addr == `OFS_STATUS)   ? stat_word
                  : (rd_addr == `OFS_COUNT)    ? wd_cnt[31:0]
                  :                              32'h00000000;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            hrdata <= 32'h00000000;
        end else if (addr_take & ~hwrite) begin
            hrdata <= rd_mux;
        end
    end
endmodule

// File: core/rsw_consts.svh
`ifndef RSW_CONSTS_SVH
`define RSW_CONSTS_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define CLK_MHZ        125
`define MR_MIN_NS      1000
`define MR_MIN_CYC     ((`MR_MIN_NS * `CLK_MHZ + 999) / 1000)
// seconds per farad expressed as ns per pF
`define RST_NS_PER_PF  4940
`define WIN_NS_PER_PF  650000
// clock cycles per pF, doubled to stay integral
`define RST_CYC_PF_X2  (`RST_NS_PER_PF * `CLK_MHZ / 500)
`define WIN_CYC_PF_X2  (`WIN_NS_PER_PF * `CLK_MHZ / 500)
`define EXT_SHIFT      7
`define RATIO_LL_SHIFT 3'd3
`define RATIO_LH_SHIFT 3'd4
`define RATIO_HH_SHIFT 3'd6

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_CTRL       8'h00
`define OFS_RST_SET    8'h04
`define OFS_WDOG_SET   8'h08
`define OFS_STATUS     8'h0C
`define OFS_COUNT      8'h10

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define CTRL_WINDOWED  0
`define CTRL_AUX_EN    1
`define CTRL_RST       2'h0
`define STAT_RESET     0
`define STAT_MR        1
`define STAT_STICKY    2
`define STAT_WIN_OFF   5
`define STAT_RANGE     6
`define PIN_IDLE       6'h21

`endif

// File: core/rsw_pkg.sv
package rsw_pkg;

    typedef logic [31:0] word_t;

    typedef enum logic [2:0] {
        ST_RUN     = 3'b001,
        ST_HOLD    = 3'b010,
        ST_STRETCH = 3'b100
    } sup_state_t;

endpackage

// File: tb/proc_model.sv
module proc_model (
    input  wire logic        mclk,
    input  wire logic        proc_reset_n,
    input  wire logic [19:0] kick_period,
    output logic             watchdog_kick
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [19:0] since;
    logic [5:0]  low_left;

    initial watchdog_kick = 1'b1;

    // ********
    // kick generator
    // ********
    always @(posedge mclk) begin
        if (!proc_reset_n || kick_period == 20'h0) begin
            since         <= 20'h0;
            low_left      <= 6'h0;
            watchdog_kick <= 1'b1;
        end else if (low_left != 6'h0) begin
            low_left      <= low_left - 6'h1;
            since         <= since + 20'h1;
            watchdog_kick <= (low_left == 6'h1);
        end else if (since + 20'h1 >= kick_period) begin
            since         <= 20'h0;
            low_left      <= 6'd38;
            watchdog_kick <= 1'b0;
        end else
            since <= since + 20'h1;
    end
endmodule

// File: tb/reset_supervisor_watchdog_asserts.sv
`include "rsw_consts.svh"

module reset_supervisor_watchdog_asserts (
    input wire logic           mclk,
    input wire logic           reset_n,
    input wire logic           hsel,
    input wire logic           hready,
    input wire logic [1:0]     htrans,
    input wire logic [31:0]    haddr,
    input wire logic           hwrite,
    input wire rsw_pkg::word_t hrdata,
    input wire logic           manual_reset_n,
    input wire logic           watchdog_range_select,
    input wire logic           proc_reset_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // ********
    // helper logic
    // ********
    logic [7:0] man_low;
    wire        rd_stat = hsel && hready && htrans[1] && !hwrite && haddr[7:0] == `OFS_STATUS;

    always_ff @(posedge mclk) begin
        if (!reset_n || manual_reset_n)
            man_low <= 8'h00;
        else if (man_low != 8'hFF)
            man_low <= man_low + 8'h01;
    end

    default clocking dc @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // ********
    // properties
    // ********
    property p_man_hold;
        man_low >= 8'd135 |-> !proc_reset_n;
    endproperty
    a_man_hold: assert property (p_man_hold) else $error("manual low, no reset");

    property p_stat_man;
        rd_stat && man_low >= 8'd135 |=> hrdata[1];
    endproperty
    a_stat_man: assert property (p_stat_man) else $error("manual flag missing");

    property p_man_idle;
        (manual_reset_n [*5]) ##0 rd_stat |=> !hrdata[1];
    endproperty
    a_man_idle: assert property (p_man_idle) else $error("idle manual qualified");

    property p_man_release;
        $rose(manual_reset_n) && man_low >= 8'd135 |-> !proc_reset_n [*3];
    endproperty
    a_man_release: assert property (p_man_release) else $error("reset not stretched");

    property p_fall_hold;
        $fell(proc_reset_n) |-> !proc_reset_n [*2];
    endproperty
    a_fall_hold: assert property (p_fall_hold) else $error("reset pulse short");

    property p_rise_clear;
        $rose(proc_reset_n) |-> man_low == 8'h00 && $past(man_low, 2) == 8'h00;
    endproperty
    a_rise_clear: assert property (p_rise_clear) else $error("release with manual low");

    property p_stat_reset;
        ($stable(proc_reset_n) [*3]) ##0 rd_stat |=> hrdata[0] == !$past(proc_reset_n);
    endproperty
    a_stat_reset: assert property (p_stat_reset) else $error("reset flag wrong");

    property p_stat_range;
        ($stable(watchdog_range_select) [*6]) ##0 rd_stat
            |=> hrdata[6] == $past(watchdog_range_select);
    endproperty
    a_stat_range: assert property (p_stat_range) else $error("range flag wrong");
endmodule

// File: tb/reset_supervisor_watchdog_bench.sv
`include "rsw_consts.svh"
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD %s expected %0h seen %0h", nm, exp, got); end end

module reset_supervisor_watchdog_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rsw_pkg::*;

    localparam int         HOLD1 = `RST_CYC_PF_X2 >> 1;
    localparam int         HOLD2 = `RST_CYC_PF_X2;
    localparam logic [1:0] CFG [5] = '{2'b11, 2'b00, 2'b01, 2'b10, 2'b11};
    localparam logic [4:0] FLT   = 5'b01001;

    logic        mclk, reset_n, hsel, hwrite, manual_reset_n, aux_monitor_ok;
    logic        watchdog_range_select, window_ratio_strap_a, window_ratio_strap_b;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr;
    logic [19:0] kick_period;
    word_t       hwdata, hrdata, rdata;
    wire logic   hready;
    logic        hreadyout, hresp, proc_reset_n, watchdog_kick;
    int          bad_count = 0;
    int          checks_done = 0;
    int          n;

    assign hready = hreadyout;

    reset_supervisor_watchdog #(.RST_SET_DEFAULT(1), .WDG_SET_DEFAULT(1))
        reset_supervisor_watchdog_inst (.mclk(mclk), .reset_n(reset_n), .hsel(hsel),
        .hready(hready), .htrans(htrans), .haddr(haddr), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .manual_reset_n(manual_reset_n), .watchdog_kick(watchdog_kick),
        .watchdog_range_select(watchdog_range_select),
        .window_ratio_strap_a(window_ratio_strap_a),
        .window_ratio_strap_b(window_ratio_strap_b), .aux_monitor_ok(aux_monitor_ok),
        .proc_reset_n(proc_reset_n));

    proc_model proc_model_inst (.mclk(mclk), .proc_reset_n(proc_reset_n),
        .kick_period(kick_period), .watchdog_kick(watchdog_kick));

    // ********
    // tasks
    // ********
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic bus(input logic [7:0] a, input logic wr, input word_t d);
        int w = 0;
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        for (int ph = 0; ph < 2; ph++) begin
            do begin
                @(posedge mclk);
                w++;
            end while (hready !== 1'b1 && w < 16);
            hsel   <= 1'b0;
            htrans <= 2'b00;
            hwdata <= d;
        end
        rdata = hrdata;
        if (w >= 16) begin
            bad_count++;
            summarize();
        end
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input word_t exp);
        bus(a, 1'b0, 32'h0);
        `CHK(nm, exp, rdata)
    endtask

    task automatic wait_lvl(input logic lvl, input int lim);
        n = 0;
        while (proc_reset_n !== lvl && n < lim) begin
            @(negedge mclk);
            n++;
        end
    endtask

    task automatic span(input string nm, input logic lvl, input int exp);
        wait_lvl(lvl, exp + 50);
        `CHK(nm, 1'b1, (n >= exp - 2 && n <= exp + 8))
    endtask

    task automatic quiet(input string nm, input int cyc);
        wait_lvl(1'b0, cyc);
        `CHK(nm, cyc, n)
    endtask

    // ********
    // stimulus
    // ********
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    initial begin
        repeat (100000) @(posedge mclk);
        bad_count++;
        summarize();
    end

    initial begin
        reset_n = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        hsize = 3'b010;
        haddr = 32'h0;
        hwdata = 32'h0;
        manual_reset_n = 1'b1;
        aux_monitor_ok = 1'b1;
        watchdog_range_select = 1'b0;
        window_ratio_strap_a = 1'b0;
        window_ratio_strap_b = 1'b0;
        kick_period = 20'd400;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        span("boot hold", 1'b1, HOLD1 + 1);
        rd_chk("ctrl", `OFS_CTRL, 32'h0);
        rd_chk("rst set", `OFS_RST_SET, 32'h1);
        rd_chk("wdog set", `OFS_WDOG_SET, 32'h1);
        bus(8'h14, 1'b1, 32'hFFFF_FFFF);
        rd_chk("unmapped", 8'h14, 32'h0);
        quiet("kicked", 3000);
        @(posedge mclk);
        kick_period <= 20'h0;
        wait_lvl(1'b0, 1000);
        `CHK("std fault", 1'b0, proc_reset_n)
        span("fault hold", 1'b1, HOLD1);
        span("post release", 1'b0, HOLD1 + 1);
        bus(`OFS_STATUS, 1'b0, 32'h0);
        `CHK("timeout flag", 1'b1, rdata[4])
        wait_lvl(1'b1, 1000);
        for (int i = 0; i < 6; i++) begin
            @(posedge mclk);
            watchdog_range_select <= ~watchdog_range_select;
            wait_lvl(1'b0, 400);
            `CHK("range change", 400, n)
        end
        @(posedge mclk);
        watchdog_range_select <= 1'b1;
        quiet("extended", 1500);
        @(posedge mclk);
        watchdog_range_select <= 1'b0;
        span("normal again", 1'b0, HOLD1 + 3);
        wait_lvl(1'b1, 1000);
        bus(`OFS_WDOG_SET, 1'b1, 32'h0);
        quiet("period zero", 2000);
        bus(`OFS_RST_SET, 1'b1, 32'h2);
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk);
            manual_reset_n <= 1'b0;
            repeat (i == 0 ? 12 : 120) @(posedge mclk);
            manual_reset_n <= 1'b1;
            quiet("short manual", 300);
        end
        @(posedge mclk);
        manual_reset_n <= 1'b0;
        repeat (140) @(posedge mclk);
        bus(`OFS_STATUS, 1'b0, 32'h0);
        `CHK("manual status", 2'b11, rdata[1:0])
        manual_reset_n <= 1'b1;
        span("manual hold", 1'b1, HOLD2 + 3);
        bus(`OFS_CTRL, 1'b1, 32'h2);
        aux_monitor_ok <= 1'b0;
        repeat (200) @(posedge mclk);
        `CHK("aux low", 1'b0, proc_reset_n)
        aux_monitor_ok <= 1'b1;
        span("aux hold", 1'b1, HOLD2 + 3);
        bus(`OFS_CTRL, 1'b1, 32'h1);
        bus(`OFS_RST_SET, 1'b1, 32'h1);
        bus(`OFS_WDOG_SET, 1'b1, 32'h1);
        for (int i = 0; i < 5; i++) begin
            @(posedge mclk);
            {window_ratio_strap_a, window_ratio_strap_b} <= CFG[i];
            kick_period <= i < 3 ? 20'd2000 : 20'd600;
            wait_lvl(1'b0, 4500);
            `CHK("window ratio", FLT[i], proc_reset_n)
            @(posedge mclk);
            kick_period <= 20'h0;
            wait_lvl(1'b1, 1000);
        end
        bus(`OFS_STATUS, 1'b0, 32'h0);
        `CHK("fast flag", 1'b1, rdata[2])
        summarize();
    end
endmodule

bind reset_supervisor_watchdog reset_supervisor_watchdog_asserts
    reset_supervisor_watchdog_asserts_inst (.mclk(mclk), .reset_n(reset_n), .hsel(hsel),
    .hready(hready), .htrans(htrans), .haddr(haddr), .hwrite(hwrite), .hrdata(hrdata),
    .manual_reset_n(manual_reset_n), .watchdog_range_select(watchdog_range_select),
    .proc_reset_n(proc_reset_n));
